// ===== hdl/isv_widget_verbs.sv
`timescale 1ns/1ps
module isv_widget_verbs
  import isv_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic bit_clk,
  input wire logic link_rst_n,
  input wire logic link_sync,
  input wire logic link_sdo,
  output logic link_sdi_o,
  output logic link_sdi_oe,
  output logic [2:0] sel_out_gain_right,
  output logic [2:0] sel_out_gain_left,
  output logic [2:0] sel_connection_choice,
  output logic [3:0] vol0_in_gain_right,
  output logic [3:0] vol0_in_gain_left,
  output logic [3:0] vol1_in_gain_right,
  output logic [3:0] vol1_in_gain_left
);

  isv_link_regs_t lnk_q;
  isv_link_regs_t lnk_d;
  isv_sys_regs_t sys_q;
  isv_sys_regs_t sys_d;

  // ********************************************************************
  // Link side, clocked by the controller's bit clock
  // ********************************************************************

  // A frame opens at the falling edge of sync; the command follows MSB first.
  // The response toggle is brought in through two flops before it is compared.
  always_comb begin
    lnk_d = lnk_q;
    lnk_d.sync_prev = link_sync;
    lnk_d.rsp_sync = {lnk_q.rsp_sync[0], sys_q.rsp_tgl};
    if (lnk_q.tx_busy) begin
      lnk_d.tx_sr = {lnk_q.tx_sr[31:0], 1'b0};
      lnk_d.tx_cnt = lnk_q.tx_cnt + 6'h01;
      if (lnk_q.tx_cnt == RSP_LAST) begin
        lnk_d.tx_busy = 1'b0;
      end
    end
    case (lnk_q.st)
      ISV_LINK_IDLE: begin
        if (lnk_q.sync_prev && !link_sync) begin
          lnk_d.cmd_sr = {lnk_q.cmd_sr[38:0], link_sdo};
          lnk_d.cmd_cnt = 6'h01;
          lnk_d.st = ISV_LINK_CMD;
          // A pending answer leaves in the frame after it became ready.
          if (lnk_q.rsp_sync[1] != lnk_q.rsp_seen) begin
            lnk_d.rsp_seen = lnk_q.rsp_sync[1];
            lnk_d.tx_sr = {1'b1, sys_q.rsp_word};
            lnk_d.tx_busy = 1'b1;
            lnk_d.tx_cnt = 6'h00;
          end
        end
      end
      ISV_LINK_CMD: begin
        lnk_d.cmd_sr = {lnk_q.cmd_sr[38:0], link_sdo};
        lnk_d.cmd_cnt = lnk_q.cmd_cnt + 6'h01;
        if (lnk_q.cmd_cnt == CMD_LAST) begin
          lnk_d.st = ISV_LINK_DONE;
        end
      end
      ISV_LINK_DONE: begin
        // Hold word stays still until the next toggle, so the far side may read it freely.
        if (lnk_q.cmd_sr[39:36] == CODEC_ADDR) begin
          lnk_d.cmd_hold = lnk_q.cmd_sr;
          lnk_d.cmd_tgl = !lnk_q.cmd_tgl;
        end
        lnk_d.st = ISV_LINK_IDLE;
      end
      default: begin
        lnk_d.st = ISV_LINK_IDLE;
      end
    endcase
  end

  // Link reset comes from the controller on the same clock.
  always_ff @(posedge bit_clk) begin
    if (!link_rst_n) begin
      lnk_q <= '0;
    end else begin
      lnk_q <= lnk_d;
    end
  end

  assign link_sdi_o = lnk_q.tx_busy & lnk_q.tx_sr[32];
  assign link_sdi_oe = lnk_q.tx_busy;

  // ********************************************************************
  // Verb decode and widget state, clocked by sys_clk
  // ********************************************************************

  logic [7:0] node;
  logic [11:0] verb;
  logic [7:0] payload;
  logic new_cmd;

  assign node = lnk_q.cmd_hold[35:28];
  assign verb = lnk_q.cmd_hold[19:8];
  assign payload = lnk_q.cmd_hold[7:0];
  assign new_cmd = sys_q.cmd_sync[1] != sys_q.cmd_seen;

  // Unknown verbs on our nodes answer zero; other nodes belong elsewhere and get no answer.
  always_comb begin
    logic mine;
    logic [31:0] rsp;
    mine = 1'b1;
    rsp = 32'h0000_0000;
    sys_d = sys_q;
    sys_d.cmd_sync = {sys_q.cmd_sync[0], lnk_q.cmd_tgl};
    if (new_cmd) begin
      sys_d.cmd_seen = sys_q.cmd_sync[1];
      case (node)
        NODE_SECOND_INPUT_SELECTOR: begin
          case (verb)
            VERB_GET_PARAM: begin
              if (payload == PARAM_WIDGET_CAPS) begin
                rsp = SECOND_INPUT_SELECTOR_CAPS;
              end else if (payload == PARAM_OUT_AMP_CAPS) begin
                rsp = OUTPUT_AMP_CAPS;
              end else if (payload == PARAM_LIST_LENGTH) begin
                rsp = SELECTOR_LIST_LENGTH;
              end
            end
            VERB_GET_OUT_RIGHT: rsp = {29'h0, sys_q.out_gain_right};
            VERB_GET_OUT_LEFT: rsp = {29'h0, sys_q.out_gain_left};
            VERB_GET_CHOICE: rsp = {29'h0, sys_q.choice};
            VERB_GET_LIST: begin
              if (payload == LIST_FROM_ENTRY0) begin
                rsp = SELECTOR_ENTRIES_LOW;
              end else if (payload == LIST_FROM_ENTRY4) begin
                rsp = SELECTOR_ENTRIES_HIGH;
              end
            end
            VERB_SET_OUT_RIGHT: begin
              // Codes above 40 dB have no step behind them, so such writes are dropped.
              if (payload[2:0] <= OUT_GAIN_MAX) begin
                sys_d.out_gain_right = payload[2:0];
              end
              rsp = WRITE_ACK;
            end
            VERB_SET_OUT_LEFT: begin
              if (payload[2:0] <= OUT_GAIN_MAX) begin
                sys_d.out_gain_left = payload[2:0];
              end
              rsp = WRITE_ACK;
            end
            VERB_SET_CHOICE: begin
              sys_d.choice = payload[2:0];
              rsp = WRITE_ACK;
            end
            default: rsp = 32'h0000_0000;
          endcase
        end
        NODE_FIRST_VOLUME, NODE_SECOND_VOLUME: begin
          case (verb)
            VERB_GET_PARAM: begin
              if (payload == PARAM_WIDGET_CAPS) begin
                rsp = VOLUME_CAPS;
              end else if (payload == PARAM_LIST_LENGTH) begin
                rsp = VOLUME_LIST_LENGTH;
              end
            end
            VERB_GET_LIST: begin
              if (payload == LIST_FROM_ENTRY0) begin
                rsp = (node == NODE_FIRST_VOLUME) ? FIRST_VOLUME_ENTRIES : SECOND_VOLUME_ENTRIES;
              end
            end
            VERB_GET_IN_RIGHT: begin
              rsp = {28'h0, (node == NODE_FIRST_VOLUME) ? sys_q.vol0_right : sys_q.vol1_right};
            end
            VERB_GET_IN_LEFT: begin
              rsp = {28'h0, (node == NODE_FIRST_VOLUME) ? sys_q.vol0_left : sys_q.vol1_left};
            end
            VERB_SET_IN_RIGHT: begin
              if (node == NODE_FIRST_VOLUME) begin
                sys_d.vol0_right = payload[3:0];
              end else begin
                sys_d.vol1_right = payload[3:0];
              end
              rsp = WRITE_ACK;
            end
            VERB_SET_IN_LEFT: begin
              if (node == NODE_FIRST_VOLUME) begin
                sys_d.vol0_left = payload[3:0];
              end else begin
                sys_d.vol1_left = payload[3:0];
              end
              rsp = WRITE_ACK;
            end
            default: rsp = 32'h0000_0000;
          endcase
        end
        NODE_CAPTURE_SELECTOR_ZERO: begin
          if (verb == VERB_GET_PARAM && payload == PARAM_WIDGET_CAPS) begin
            rsp = CAPTURE_SELECTOR_ZERO_CAPS;
          end
        end
        default: mine = 1'b0;
      endcase
      if (mine) begin
        sys_d.rsp_word = rsp;
        sys_d.rsp_tgl = !sys_q.rsp_tgl;
      end
    end
  end

  // Control fields come out of reset at their documented defaults.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sys_q <= '0;
      sys_q.out_gain_right <= OUT_GAIN_RESET;
      sys_q.out_gain_left <= OUT_GAIN_RESET;
      sys_q.choice <= CHOICE_RESET;
      sys_q.vol0_right <= IN_GAIN_RESET;
      sys_q.vol0_left <= IN_GAIN_RESET;
      sys_q.vol1_right <= IN_GAIN_RESET;
      sys_q.vol1_left <= IN_GAIN_RESET;
    end else begin
      sys_q <= sys_d;
    end
  end

  assign sel_out_gain_right = sys_q.out_gain_right;
  assign sel_out_gain_left = sys_q.out_gain_left;
  assign sel_connection_choice = sys_q.choice;
  assign vol0_in_gain_right = sys_q.vol0_right;
  assign vol0_in_gain_left = sys_q.vol0_left;
  assign vol1_in_gain_right = sys_q.vol1_right;
  assign vol1_in_gain_left = sys_q.vol1_left;

endmodule : isv_widget_verbs

// ===== include/isv_pkg.sv
package isv_pkg;

  // ********************************************************************
  // Link framing
  // ********************************************************************
  localparam int unsigned CMD_BITS = 40;  // Command word length on the outbound line.
  localparam int unsigned RSP_BITS = 33;  // Valid flag followed by the 32-bit answer.
  localparam logic [5:0] CMD_LAST = 6'h27;
  localparam logic [5:0] RSP_LAST = 6'h20;
  localparam logic [3:0] CODEC_ADDR = 4'h0;  // Codec address this device answers to.

  // ********************************************************************
  // Node identifiers
  // ********************************************************************
  localparam logic [7:0] NODE_SECOND_INPUT_SELECTOR = 8'h1a;
  localparam logic [7:0] NODE_FIRST_VOLUME = 8'h1b;
  localparam logic [7:0] NODE_SECOND_VOLUME = 8'h1c;
  localparam logic [7:0] NODE_CAPTURE_SELECTOR_ZERO = 8'h1d;
  localparam logic [7:0] NODE_FIRST_INPUT_SELECTOR = 8'h19;

  // ********************************************************************
  // Verbs and payloads
  // ********************************************************************
  localparam logic [11:0] VERB_GET_PARAM = 12'hf00;
  localparam logic [11:0] VERB_GET_CHOICE = 12'hf01;
  localparam logic [11:0] VERB_SET_CHOICE = 12'h701;
  localparam logic [11:0] VERB_GET_LIST = 12'hf02;
  localparam logic [11:0] VERB_GET_OUT_RIGHT = 12'hb80;
  localparam logic [11:0] VERB_SET_OUT_RIGHT = 12'h390;
  localparam logic [11:0] VERB_GET_OUT_LEFT = 12'hba0;
  localparam logic [11:0] VERB_SET_OUT_LEFT = 12'h3a0;
  localparam logic [11:0] VERB_GET_IN_RIGHT = 12'hb00;
  localparam logic [11:0] VERB_SET_IN_RIGHT = 12'h350;
  localparam logic [11:0] VERB_GET_IN_LEFT = 12'hb20;
  localparam logic [11:0] VERB_SET_IN_LEFT = 12'h360;
  localparam logic [7:0] PARAM_WIDGET_CAPS = 8'h09;
  localparam logic [7:0] PARAM_OUT_AMP_CAPS = 8'h12;
  localparam logic [7:0] PARAM_LIST_LENGTH = 8'h0e;
  localparam logic [7:0] LIST_FROM_ENTRY0 = 8'h00;
  localparam logic [7:0] LIST_FROM_ENTRY4 = 8'h04;

  // ********************************************************************
  // Capability word fields
  // ********************************************************************
  localparam int unsigned TYPE_LSB = 20;
  localparam logic [3:0] TYPE_AUDIO_SELECTOR = 4'h3;
  localparam int unsigned CHANNEL_SWAP_CAPABLE_BIT = 11;
  localparam int unsigned HAS_CONNECTION_LIST_BIT = 8;
  localparam int unsigned AMP_PARAMS_LOCAL_BIT = 3;
  localparam int unsigned OUTPUT_AMP_EXISTS_BIT = 2;
  localparam int unsigned INPUT_AMP_EXISTS_BIT = 1;
  localparam int unsigned STEREO_BIT = 0;
  localparam logic [31:0] CAPS_BASE = (32'(TYPE_AUDIO_SELECTOR) << TYPE_LSB) | (32'h1 << STEREO_BIT);
  localparam logic [31:0] SECOND_INPUT_SELECTOR_CAPS = CAPS_BASE | (32'h1 << HAS_CONNECTION_LIST_BIT)
      | (32'h1 << AMP_PARAMS_LOCAL_BIT) | (32'h1 << OUTPUT_AMP_EXISTS_BIT);
  localparam logic [31:0] VOLUME_CAPS = CAPS_BASE | (32'h1 << HAS_CONNECTION_LIST_BIT)
      | (32'h1 << INPUT_AMP_EXISTS_BIT);
  localparam logic [31:0] CAPTURE_SELECTOR_ZERO_CAPS = SECOND_INPUT_SELECTOR_CAPS
      | (32'h1 << CHANNEL_SWAP_CAPABLE_BIT);

  // ********************************************************************
  // Amplifier and connection list constants
  // ********************************************************************
  localparam int unsigned GAIN_STEP_WIDTH_LSB = 16;
  localparam int unsigned GAIN_STEP_COUNT_LSB = 8;
  localparam logic [6:0] GAIN_STEP_WIDTH_10DB = 7'h27;
  localparam logic [6:0] GAIN_STEP_COUNT = 7'h04;
  localparam logic [31:0] OUTPUT_AMP_CAPS = (32'(GAIN_STEP_WIDTH_10DB) << GAIN_STEP_WIDTH_LSB)
      | (32'(GAIN_STEP_COUNT) << GAIN_STEP_COUNT_LSB);
  localparam logic [2:0] OUT_GAIN_MAX = 3'h4;  // Code for 40 dB.
  localparam logic [2:0] OUT_GAIN_RESET = 3'h0;
  localparam logic [3:0] IN_GAIN_RESET = 4'h0;
  localparam logic [2:0] CHOICE_RESET = 3'h0;  // First entry, Port E.
  localparam logic [31:0] SELECTOR_LIST_LENGTH = 32'h0000_0007;  // Short form, seven entries.
  localparam logic [31:0] VOLUME_LIST_LENGTH = 32'h0000_0001;
  localparam logic [31:0] SELECTOR_ENTRIES_LOW = 32'h0b0f_160e;
  localparam logic [31:0] SELECTOR_ENTRIES_HIGH = 32'h000a_0d0c;
  localparam logic [31:0] FIRST_VOLUME_ENTRIES = 32'(NODE_FIRST_INPUT_SELECTOR);
  localparam logic [31:0] SECOND_VOLUME_ENTRIES = 32'(NODE_SECOND_INPUT_SELECTOR);
  localparam logic [31:0] WRITE_ACK = 32'h0000_0000;

  // ********************************************************************
  // State types
  // ********************************************************************
  typedef enum logic [1:0] {
    ISV_LINK_IDLE = 2'b00,
    ISV_LINK_CMD = 2'b01,
    ISV_LINK_DONE = 2'b10
  } isv_link_state_t;

  typedef struct packed {
    isv_link_state_t st;
    logic sync_prev;
    logic [5:0] cmd_cnt;
    logic [39:0] cmd_sr;
    logic [39:0] cmd_hold;
    logic cmd_tgl;
    logic [1:0] rsp_sync;
    logic rsp_seen;
    logic tx_busy;
    logic [5:0] tx_cnt;
    logic [32:0] tx_sr;
  } isv_link_regs_t;

  typedef struct packed {
    logic [1:0] cmd_sync;
    logic cmd_seen;
    logic [31:0] rsp_word;
    logic rsp_tgl;
    logic [2:0] out_gain_right;
    logic [2:0] out_gain_left;
    logic [2:0] choice;
    logic [3:0] vol0_right;
    logic [3:0] vol0_left;
    logic [3:0] vol1_right;
    logic [3:0] vol1_left;
  } isv_sys_regs_t;

endpackage : isv_pkg

// ===== test/isv_link_host.sv
`timescale 1ns/1ps
// ********************************************************************
// Controller model on the link
// ********************************************************************
module isv_link_host (
  input wire logic bit_clk,
  output logic link_sync,
  output logic link_sdo,
  input wire logic link_sdi_o,
  input wire logic link_sdi_oe
);
  logic sdi_line;
  // A released answer line falls to its pull-down level.
  assign sdi_line = link_sdi_oe ? link_sdi_o : 1'b0;
  // Sync idles high so no frame opens before the first command.
  initial begin
    link_sync = 1'b1;
    link_sdo = 1'b0;
  end
  // One 64-slot frame: 40 command bits MSB first, then a toggling line once the hold has run out.
  task automatic frame(input logic [39:0] cmd, output logic [32:0] rsp, output int n_oe);
    rsp = '0;
    n_oe = 0;
    @(posedge bit_clk);
    link_sync <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      @(posedge bit_clk);
      link_sync <= 1'b0;
      link_sdo <= (i < 40) ? cmd[39 - i] : ~link_sdo;
      #1;
      if (link_sdi_oe) begin
        rsp = {rsp[31:0], sdi_line};
        n_oe++;
      end
    end
  endtask : frame
endmodule : isv_link_host

// ===== test/isv_widget_verbs_assertions.sv
`timescale 1ns/1ps
// ********************************************************************
// Link and control checks
// ********************************************************************
module isv_widget_verbs_chk
  import isv_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic bit_clk,
  input wire logic link_rst_n,
  input wire logic link_sync,
  input wire logic link_sdo,
  input wire logic link_sdi_o,
  input wire logic link_sdi_oe,
  input wire logic [2:0] sel_out_gain_right,
  input wire logic [2:0] sel_out_gain_left,
  input wire logic [2:0] sel_connection_choice,
  input wire logic [3:0] vol0_in_gain_right,
  input wire logic [3:0] vol0_in_gain_left,
  input wire logic [3:0] vol1_in_gain_right,
  input wire logic [3:0] vol1_in_gain_left
);
  logic [5:0] oe_run_q;
  // Burst length is counted, since a repetition of 33 slots is far too long to unroll.
  always_ff @(posedge bit_clk) begin
    if (!link_rst_n) oe_run_q <= 6'h00;
    else if (link_sdi_oe) oe_run_q <= oe_run_q + 6'h01;
    else oe_run_q <= 6'h00;
  end
  property p_oe_len; @(posedge bit_clk) disable iff (!link_rst_n) $fell(link_sdi_oe) |-> oe_run_q == 6'h21; endproperty
  a_oe_len: assert property (p_oe_len) else $error("answer burst not 33 slots");
  property p_oe_max; @(posedge bit_clk) disable iff (!link_rst_n) oe_run_q <= 6'h21; endproperty
  a_oe_max: assert property (p_oe_max) else $error("answer burst too long");
  property p_valid; @(posedge bit_clk) disable iff (!link_rst_n) $rose(link_sdi_oe) |-> link_sdi_o; endproperty
  a_valid: assert property (p_valid) else $error("first answer bit not set");
  property p_idle; @(posedge bit_clk) disable iff (!link_rst_n) !link_sdi_oe |-> !link_sdi_o; endproperty
  a_idle: assert property (p_idle) else $error("answer bit high while released");
  property p_start;
    @(posedge bit_clk) disable iff (!link_rst_n) $rose(link_sdi_oe) |-> !$past(link_sync) && $past(link_sync, 2);
  endproperty
  a_start: assert property (p_start) else $error("answer not aligned to frame start");
  property p_gain_max; @(posedge sys_clk) disable iff (rst) sel_out_gain_right <= 3'h4 && sel_out_gain_left <= 3'h4;
  endproperty
  a_gain_max: assert property (p_gain_max) else $error("output gain code above 40 dB");
  property p_reset_zero;
    @(posedge sys_clk) disable iff (rst) $fell(rst) |-> {sel_out_gain_right, sel_out_gain_left, sel_connection_choice,
      vol0_in_gain_right, vol0_in_gain_left, vol1_in_gain_right, vol1_in_gain_left} == 25'h0;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("controls not zero after reset");
  property p_one_field;
    @(posedge sys_clk) disable iff (rst) $onehot0({$changed(sel_out_gain_right), $changed(sel_out_gain_left),
      $changed(sel_connection_choice), $changed(vol0_in_gain_right), $changed(vol0_in_gain_left),
      $changed(vol1_in_gain_right), $changed(vol1_in_gain_left)});
  endproperty
  a_one_field: assert property (p_one_field) else $error("one write changed several controls");
endmodule : isv_widget_verbs_chk

bind isv_widget_verbs isv_widget_verbs_chk u_chk (.sys_clk(sys_clk), .rst(rst), .bit_clk(bit_clk),
  .link_rst_n(link_rst_n), .link_sync(link_sync), .link_sdo(link_sdo), .link_sdi_o(link_sdi_o),
  .link_sdi_oe(link_sdi_oe), .sel_out_gain_right(sel_out_gain_right), .sel_out_gain_left(sel_out_gain_left),
  .sel_connection_choice(sel_connection_choice), .vol0_in_gain_right(vol0_in_gain_right),
  .vol0_in_gain_left(vol0_in_gain_left), .vol1_in_gain_right(vol1_in_gain_right),
  .vol1_in_gain_left(vol1_in_gain_left));

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import isv_pkg::*;
();
  logic sys_clk, bit_clk, rst, link_rst_n, link_sync, link_sdo, link_sdi_o, link_sdi_oe;
  logic [2:0] sel_out_gain_right, sel_out_gain_left, sel_connection_choice;
  logic [3:0] vol0_in_gain_right, vol0_in_gain_left, vol1_in_gain_right, vol1_in_gain_left;
  logic [24:0] all_ctl;
  int n_errors = 0;
  int n_compared = 0;
  logic [19:0] rd_tab [7] = '{20'h1a_b80, 20'h1a_ba0, 20'h1a_f01, 20'h1b_b00, 20'h1b_b20, 20'h1c_b00, 20'h1c_b20};
  // All control outputs in one vector.
  assign all_ctl = {sel_out_gain_right, sel_out_gain_left, sel_connection_choice, vol0_in_gain_right,
    vol0_in_gain_left, vol1_in_gain_right, vol1_in_gain_left};
  // ********************************************************************
  // Clocks, design and link partner
  // ********************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Link clock is offset so its edges never line up with the system clock.
  initial begin
    bit_clk = 1'b0;
    #3.7;
    forever #6 bit_clk = ~bit_clk;
  end
  isv_widget_verbs uut (.sys_clk(sys_clk), .rst(rst), .bit_clk(bit_clk), .link_rst_n(link_rst_n),
    .link_sync(link_sync), .link_sdo(link_sdo), .link_sdi_o(link_sdi_o), .link_sdi_oe(link_sdi_oe),
    .sel_out_gain_right(sel_out_gain_right), .sel_out_gain_left(sel_out_gain_left),
    .sel_connection_choice(sel_connection_choice), .vol0_in_gain_right(vol0_in_gain_right),
    .vol0_in_gain_left(vol0_in_gain_left), .vol1_in_gain_right(vol1_in_gain_right),
    .vol1_in_gain_left(vol1_in_gain_left));
  isv_link_host host (.bit_clk(bit_clk), .link_sync(link_sync), .link_sdo(link_sdo), .link_sdi_o(link_sdi_o),
    .link_sdi_oe(link_sdi_oe));
  // ********************************************************************
  // Shared tasks
  // ********************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Both domains are reset together; a lone reset could leave a stray answer.
  task automatic do_reset();
    rst <= 1'b1;
    link_rst_n <= 1'b0;
    repeat (3) @(posedge bit_clk);
    @(posedge sys_clk) rst <= 1'b0;
    @(posedge bit_clk) link_rst_n <= 1'b1;
    repeat (4) @(posedge bit_clk);
  endtask : do_reset
  // The answer comes in the next frame, so a frame to an absent codec fetches it.
  task automatic xact(input logic [7:0] nd, input logic [11:0] vb, input logic [7:0] pl, output logic [31:0] r);
    logic [32:0] a;
    int n;
    host.frame({CODEC_ADDR, nd, 8'h00, vb, pl}, a, n);
    check("stray answer slots", 32'(n), 32'd0);
    host.frame({4'hf, 36'h0}, a, n);
    check("answer slots", 32'(n), 32'd33);
    check("valid flag", {31'h0, a[32]}, 32'h1);
    r = a[31:0];
  endtask : xact
  task automatic rc(input string what, input logic [7:0] nd, input logic [11:0] vb, input logic [7:0] pl,
      input logic [31:0] exp);
    logic [31:0] r;
    xact(nd, vb, pl, r);
    check(what, r, exp);
  endtask : rc
  task automatic wr(input logic [7:0] nd, input logic [11:0] vb, input logic [7:0] pl);
    logic [31:0] r;
    xact(nd, vb, pl, r);
    check("write answer", r, 32'h0);
  endtask : wr
  // ********************************************************************
  // Scenarios
  // ********************************************************************
  task automatic t_reset();
    check("controls", {7'h0, all_ctl}, 32'h0);
    foreach (rd_tab[i]) rc("reset read", rd_tab[i][19:12], rd_tab[i][11:0], 8'h00, 32'h0);
  endtask : t_reset
  task automatic t_fixed();
    rc("caps 1a", 8'h1a, 12'hf00, 8'h09, 32'h0030_010d);
    rc("caps 1b", 8'h1b, 12'hf00, 8'h09, 32'h0030_0103);
    rc("caps 1c", 8'h1c, 12'hf00, 8'h09, 32'h0030_0103);
    rc("caps 1d", 8'h1d, 12'hf00, 8'h09, 32'h0030_090d);
    rc("amp caps", 8'h1a, 12'hf00, 8'h12, 32'h0027_0400);
    rc("len 1a", 8'h1a, 12'hf00, 8'h0e, 32'h0000_0007);
    rc("len 1b", 8'h1b, 12'hf00, 8'h0e, 32'h0000_0001);
    rc("len 1c", 8'h1c, 12'hf00, 8'h0e, 32'h0000_0001);
    rc("list 1a lo", 8'h1a, 12'hf02, 8'h00, 32'h0b0f_160e);
    rc("list 1a hi", 8'h1a, 12'hf02, 8'h04, 32'h000a_0d0c);
    rc("list 1b", 8'h1b, 12'hf02, 8'h00, 32'h0000_0019);
    rc("list 1c", 8'h1c, 12'hf02, 8'h00, 32'h0000_001a);
  endtask : t_fixed
  // Sweeps both gains in opposite directions, then tries a code above 40 dB.
  task automatic t_out_gain();
    logic [2:0] c;
    for (int i = 0; i < 5; i++) begin
      c = 3'(i);
      wr(8'h1a, 12'h390, {5'h0, c});
      wr(8'h1a, 12'h3a0, {5'h0, 3'h4 - c});
      rc("out right", 8'h1a, 12'hb80, 8'h00, {29'h0, c});
      rc("out left", 8'h1a, 12'hba0, 8'h00, {29'h0, 3'h4 - c});
      check("out right port", {29'h0, sel_out_gain_right}, {29'h0, c});
    end
    wr(8'h1a, 12'h390, 8'hfd);
    rc("out right kept", 8'h1a, 12'hb80, 8'h00, 32'h4);
  endtask : t_out_gain
  task automatic t_choice();
    wr(8'h1a, 12'h701, 8'h07);
    rc("choice", 8'h1a, 12'hf01, 8'h00, 32'h7);
    wr(8'h1a, 12'h701, 8'hf9);
    rc("choice low bits", 8'h1a, 12'hf01, 8'h00, 32'h1);
  endtask : t_choice
  task automatic t_vol();
    wr(8'h1b, 12'h350, 8'h0f);
    wr(8'h1b, 12'h360, 8'h05);
    wr(8'h1c, 12'h350, 8'h0a);
    wr(8'h1c, 12'h360, 8'h03);
    rc("vol0 right", 8'h1b, 12'hb00, 8'h00, 32'hf);
    rc("vol1 left", 8'h1c, 12'hb20, 8'h00, 32'h3);
    check("controls", {7'h0, all_ctl}, {7'h0, 3'h4, 3'h0, 3'h1, 16'hf5a3});
  endtask : t_vol
  // Writes aimed at fixed words or absent controls must leave everything as it was.
  task automatic t_ro();
    logic [32:0] a;
    int n;
    // A node outside this block must get no answer at all, so the line stays released.
    host.frame({CODEC_ADDR, 8'h19, 8'h00, 12'hf00, 8'h09}, a, n);
    host.frame({4'hf, 36'h0}, a, n);
    check("foreign node slots", 32'(n), 32'd0);
    wr(8'h1d, 12'h709, 8'hff);
    wr(8'h1b, 12'h390, 8'h03);
    rc("caps 1d kept", 8'h1d, 12'hf00, 8'h09, 32'h0030_090d);
    rc("1d other verb", 8'h1d, 12'hb80, 8'h00, 32'h0);
    check("controls", {7'h0, all_ctl}, {7'h0, 3'h4, 3'h0, 3'h1, 16'hf5a3});
  endtask : t_ro
  // ********************************************************************
  // Sequence, watchdog and verdict
  // ********************************************************************
  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  initial begin
    rst = 1'b1;
    link_rst_n = 1'b0;
    do_reset();
    t_reset();
    t_fixed();
    t_out_gain();
    t_choice();
    t_vol();
    t_ro();
    do_reset();
    t_reset();
    complete_run();
  end
  // About 63 exchanges of two frames each fit well inside this span.
  initial begin
    #250us;
    n_errors++;
    complete_run();
  end
endmodule : tb_top
